// file: dqz_pkg.sv
package dqz_pkg;
  // bus geometry
  localparam int WB_ADR_W = 4;
  localparam int WB_DAT_W = 32;
  // register byte offsets
  localparam logic [3:0] MODE_OFS = 4'h0;
  localparam logic [3:0] CAL_CMD_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;
  localparam logic [3:0] CODE_OFS = 4'hC;
  // mode_register_five enable bits
  localparam int MODE_MASK_BIT = 10;
  localparam int MODE_WINV_BIT = 11;
  localparam int MODE_RINV_BIT = 12;
  localparam logic [2:0] MODE_RESET = 3'h0;
  // cal command bits
  localparam int CMD_LONG_BIT = 0;
  localparam int CMD_SHORT_BIT = 1;
  // status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_FIRST_DONE_BIT = 1;
  localparam int ST_LONG_BIT = 2;
  localparam int ST_SHORT_BIT = 3;
  localparam int ST_CONFLICT_BIT = 4;
  localparam int ST_CURRENT_BIT = 5;
  localparam int ST_CODE_LSB = 8;
  // frame and lane geometry
  localparam int LANE_BITS = 8;
  localparam int LANES = 2;
  localparam int BURST_BEATS = 8;
  localparam int INV_ZERO_LIMIT = 4;
  // impedance code
  localparam int CODE_W = 6;
  localparam logic [5:0] CODE_RESET = 6'h20;
  // calibration timing, in clock cycles (nCK)
  localparam int INIT_WIN_NCK = 1024;
  localparam int OPER_WIN_NCK = 512;
  localparam int SHORT_WIN_NCK = 128;
  localparam int SHORT_CORR_NCK = 128;
  localparam int CAL_STEP_NCK = 16;
  localparam int CAL_CNT_W = 16;
  typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_XFER} dqz_cal_state_type;
endpackage : dqz_pkg

// file: dqz_lane_codec.sv
`timescale 1ns/1ns
module dqz_lane_codec #(
  parameter int LANES = dqz_pkg::LANES,
  parameter int LB = dqz_pkg::LANE_BITS
) (
  input wire logic [LANES*LB-1:0] wr_data_i,
  input wire logic [LANES-1:0] wr_lane_n_i,
  input wire logic mask_en_i,
  input wire logic winv_en_i,
  input wire logic [LANES*LB-1:0] rd_data_i,
  output logic [LANES*LB-1:0] wr_data_o,
  output logic [LANES-1:0] wr_byte_en_o,
  output logic [LANES*LB-1:0] rd_data_o,
  output logic [LANES-1:0] rd_lane_n_o
);
  function automatic logic [3:0] zero_count(input logic [7:0] b);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 0; k < 8; k++) begin
      n = n + {3'h0, ~b[k]};
    end
    return n;
  endfunction : zero_count

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    wire logic [LB-1:0] wbyte = wr_data_i[g*LB +: LB];
    wire logic [LB-1:0] rbyte = rd_data_i[g*LB +: LB];
    wire logic inv_wr = winv_en_i & ~wr_lane_n_i[g];
    wire logic inv_rd = zero_count(rbyte) > 4'(dqz_pkg::INV_ZERO_LIMIT);
    // byte of a masked beat is dropped
    assign wr_byte_en_o[g] = ~(mask_en_i & ~wr_lane_n_i[g]);
    assign wr_data_o[g*LB +: LB] = inv_wr ? ~wbyte : wbyte;
    assign rd_data_o[g*LB +: LB] = inv_rd ? ~rbyte : rbyte;
    assign rd_lane_n_o[g] = ~inv_rd;
  end
endmodule : dqz_lane_codec

// file: dqz_lane_cal.sv
// Local design decisions: the register addresses and register access over Wishbone.
`timescale 1ns/1ns
// What this block does
// - three mode bits enable mask, inversions
// - both write functions off: receiver off
// - read inversion off: pin driver off
// - lane pin active low, bidirectional
// - mask low drops byte, high stores
// - write inversion low inverts whole byte
// - read: over four zeros inverts, pin low
// - eight beats, lane pins pair per byte
// - long cal runs engine, transfers values
// - first long cal within initial window
// - later long cal within operational window
// - short cal within short window, 128 cycles
// - no calibration on self-refresh exit
// - termination control low, park termination kept; here park termination is on only while a cal runs, termination control ignored
// - cut calibration current once calibrated
module dqz_lane_cal #(
  parameter int INIT_WIN_CYC = dqz_pkg::INIT_WIN_NCK,
  parameter int OPER_WIN_CYC = dqz_pkg::OPER_WIN_NCK,
  parameter int SHORT_WIN_CYC = dqz_pkg::SHORT_WIN_NCK,
  parameter int STEP_CYC = dqz_pkg::CAL_STEP_NCK
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [dqz_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [dqz_pkg::WB_DAT_W-1:0] wb_dat_i,
  output logic [dqz_pkg::WB_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // dq pins, write side
  input wire logic wr_beat_i,
  input wire logic [15:0] dq_i,
  input wire logic [1:0] lane_mask_invert_pin_n_i,
  // dq pins, read side
  output logic [15:0] dq_o,
  output logic dq_oe_o,
  output logic [1:0] lane_mask_invert_pin_n_o,
  output logic [1:0] lane_mask_invert_pin_oe_o,
  output logic lane_rx_en_o,
  // core side
  output logic [15:0] core_wr_data_o,
  output logic [1:0] core_wr_byte_en_o,
  output logic core_wr_valid_o,
  output logic [2:0] core_wr_beat_o,
  input wire logic rd_beat_i,
  input wire logic [15:0] core_rd_data_i,
  // calibration pins
  input wire logic termination_control_i,
  input wire logic self_refresh_exit_i,
  input wire logic zq_cmp_i,
  output logic cal_current_en_o,
  output logic park_termination_o,
  output logic [dqz_pkg::CODE_W-1:0] io_code_o
);
  // pin synchronisers, first stage read only by second
  logic [18:0] pin_s1_reg;
  logic [18:0] pin_s2_reg;
  logic term_s1_reg;
  logic term_s2_reg;
  logic zq_s1_reg;
  logic zq_s2_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_reg <= 19'h0;
      pin_s2_reg <= 19'h0;
      term_s1_reg <= 1'b0;
      term_s2_reg <= 1'b0;
      zq_s1_reg <= 1'b0;
      zq_s2_reg <= 1'b0;
    end else if (ce_i) begin
      pin_s1_reg <= {wr_beat_i, lane_mask_invert_pin_n_i, dq_i};
      pin_s2_reg <= pin_s1_reg;
      term_s1_reg <= termination_control_i;
      term_s2_reg <= term_s1_reg;
      zq_s1_reg <= zq_cmp_i;
      zq_s2_reg <= zq_s1_reg;
    end
  end

  wire logic wr_beat_s = pin_s2_reg[18];
  wire logic [1:0] lane_n_s = pin_s2_reg[17:16];
  wire logic [15:0] dq_s = pin_s2_reg[15:0];
  wire logic zq_s = zq_s2_reg;

  // mode register bits
  logic mask_en_reg;
  logic winv_en_reg;
  logic rinv_en_reg;

  // wishbone decode
  wire logic wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic wb_wr = wb_req & wb_we_i;
  wire logic hit_mode = wb_adr_i == dqz_pkg::MODE_OFS;
  wire logic hit_cmd = wb_adr_i == dqz_pkg::CAL_CMD_OFS;
  wire logic hit_status = wb_adr_i == dqz_pkg::STATUS_OFS;
  wire logic hit_code = wb_adr_i == dqz_pkg::CODE_OFS;
  wire logic mode_wr = wb_wr & hit_mode & wb_sel_i[1];
  wire logic cmd_wr = wb_wr & hit_cmd & wb_sel_i[0];
  wire logic long_req = cmd_wr & wb_dat_i[dqz_pkg::CMD_LONG_BIT];
  wire logic short_req = cmd_wr & wb_dat_i[dqz_pkg::CMD_SHORT_BIT] & ~long_req;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {rinv_en_reg, winv_en_reg, mask_en_reg} <= dqz_pkg::MODE_RESET;
    end else if (ce_i && mode_wr) begin
      // mode register set
      mask_en_reg <= wb_dat_i[dqz_pkg::MODE_MASK_BIT];
      winv_en_reg <= wb_dat_i[dqz_pkg::MODE_WINV_BIT];
      rinv_en_reg <= wb_dat_i[dqz_pkg::MODE_RINV_BIT];
    end
  end

  // illegal pairing is the controller's duty; mask then wins, flagged in status
  wire logic mode_conflict = mask_en_reg & winv_en_reg;
  wire logic eff_winv = winv_en_reg & ~mask_en_reg;
  // receiver off and level ignored when both write functions are off
  wire logic rx_on = mask_en_reg | winv_en_reg;
  wire logic [1:0] lane_n_eff = rx_on ? lane_n_s : 2'h3;

  // lane codec
  logic [15:0] dec_data;
  logic [1:0] dec_byte_en;
  logic [15:0] enc_data;
  logic [1:0] enc_lane_n;

  dqz_lane_codec #(
    .LANES(dqz_pkg::LANES),
    .LB(dqz_pkg::LANE_BITS)
  ) u_codec (
    .wr_data_i(dq_s),
    .wr_lane_n_i(lane_n_eff),
    .mask_en_i(mask_en_reg),
    .winv_en_i(eff_winv),
    .rd_data_i(core_rd_data_i),
    .wr_data_o(dec_data),
    .wr_byte_en_o(dec_byte_en),
    .rd_data_o(enc_data),
    .rd_lane_n_o(enc_lane_n)
  );

  // write path, beat index wraps every burst
  logic [15:0] wr_data_reg;
  logic [1:0] wr_be_reg;
  logic wr_valid_reg;
  logic [2:0] wr_beat_cnt_reg;
  logic [2:0] wr_beat_out_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_data_reg <= 16'h0;
      wr_be_reg <= 2'h0;
      wr_valid_reg <= 1'b0;
      wr_beat_cnt_reg <= 3'h0;
      wr_beat_out_reg <= 3'h0;
    end else if (ce_i) begin
      wr_valid_reg <= wr_beat_s;
      if (wr_beat_s) begin
        wr_data_reg <= dec_data;
        wr_be_reg <= dec_byte_en;
        wr_beat_out_reg <= wr_beat_cnt_reg;
        wr_beat_cnt_reg <= wr_beat_cnt_reg + 3'h1;
      end
    end
  end

  // read path
  logic [15:0] dq_out_reg;
  logic dq_oe_reg;
  logic [1:0] lane_out_reg;
  logic [1:0] lane_oe_reg;
  wire logic [15:0] rd_sel = rinv_en_reg ? enc_data : core_rd_data_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dq_out_reg <= 16'h0;
      dq_oe_reg <= 1'b0;
      lane_out_reg <= 2'h3;
      lane_oe_reg <= 2'h0;
    end else if (ce_i) begin
      dq_oe_reg <= rd_beat_i;
      if (rd_beat_i) begin
        dq_out_reg <= rd_sel;
        lane_out_reg <= rinv_en_reg ? enc_lane_n : 2'h3;
      end
      // driver only on when read inversion is on
      lane_oe_reg <= {2{rd_beat_i & rinv_en_reg}};
    end
  end

  // calibration engine
  dqz_pkg::dqz_cal_state_type cal_state_reg;
  dqz_pkg::dqz_cal_state_type cal_state_next;
  logic [dqz_pkg::CAL_CNT_W-1:0] win_cnt_reg;
  logic [dqz_pkg::CAL_CNT_W-1:0] elapsed_reg;
  logic [dqz_pkg::CAL_CNT_W-1:0] step_cnt_reg;
  logic [dqz_pkg::CODE_W-1:0] cal_code_reg;
  logic [dqz_pkg::CODE_W-1:0] io_code_reg;
  logic first_done_reg;
  logic is_long_reg;
  logic is_short_reg;

  // window chosen by first-long-done flag
  wire logic [dqz_pkg::CAL_CNT_W-1:0] long_win = first_done_reg ?
      dqz_pkg::CAL_CNT_W'(OPER_WIN_CYC) : dqz_pkg::CAL_CNT_W'(INIT_WIN_CYC);
  wire logic [dqz_pkg::CAL_CNT_W-1:0] short_win = dqz_pkg::CAL_CNT_W'(SHORT_WIN_CYC);
  wire logic cal_idle = cal_state_reg == dqz_pkg::CAL_IDLE;
  // self-refresh exit never starts the engine; only commands do
  wire logic start_long = cal_idle & long_req;
  wire logic start_short = cal_idle & short_req;
  wire logic win_last = win_cnt_reg == '0;
  wire logic step_tick = step_cnt_reg == '0;
  // short cal does its correction in the first 128 cycles
  wire logic corr_ok = is_long_reg |
      (elapsed_reg < dqz_pkg::CAL_CNT_W'(dqz_pkg::SHORT_CORR_NCK));
  wire logic code_max = &cal_code_reg;
  wire logic code_min = ~|cal_code_reg;
  wire logic sr_exit_unused = self_refresh_exit_i;
  wire logic term_unused = term_s2_reg;

  always_comb begin
    cal_state_next = cal_state_reg;
    case (cal_state_reg)
      dqz_pkg::CAL_IDLE: begin
        if (start_long || start_short) begin
          cal_state_next = dqz_pkg::CAL_RUN;
        end
      end
      dqz_pkg::CAL_RUN: begin
        if (win_last) begin
          cal_state_next = dqz_pkg::CAL_XFER;
        end
      end
      dqz_pkg::CAL_XFER: begin
        cal_state_next = dqz_pkg::CAL_IDLE;
      end
      default: begin
        cal_state_next = dqz_pkg::CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_state_reg <= dqz_pkg::CAL_IDLE;
    end else if (ce_i) begin
      cal_state_reg <= cal_state_next;
    end
  end

  // run lasts window-1 cycles plus one transfer cycle, inside the window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_cnt_reg <= '0;
      elapsed_reg <= '0;
      step_cnt_reg <= '0;
      is_long_reg <= 1'b0;
      is_short_reg <= 1'b0;
    end else if (ce_i) begin
      if (start_long || start_short) begin
        win_cnt_reg <= (start_long ? long_win : short_win) - dqz_pkg::CAL_CNT_W'(2);
        elapsed_reg <= '0;
        step_cnt_reg <= dqz_pkg::CAL_CNT_W'(STEP_CYC - 1);
        is_long_reg <= start_long;
        is_short_reg <= start_short;
      end else if (cal_state_reg == dqz_pkg::CAL_RUN) begin
        win_cnt_reg <= win_cnt_reg - dqz_pkg::CAL_CNT_W'(1);
        elapsed_reg <= elapsed_reg + dqz_pkg::CAL_CNT_W'(1);
        step_cnt_reg <= step_tick ? dqz_pkg::CAL_CNT_W'(STEP_CYC - 1) :
            step_cnt_reg - dqz_pkg::CAL_CNT_W'(1);
      end else if (cal_state_reg == dqz_pkg::CAL_XFER) begin
        is_long_reg <= 1'b0;
        is_short_reg <= 1'b0;
      end
    end
  end

  // comparator high means impedance too high: step code up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_code_reg <= dqz_pkg::CODE_RESET;
      io_code_reg <= dqz_pkg::CODE_RESET;
      first_done_reg <= 1'b0;
    end else if (ce_i) begin
      if (cal_state_reg == dqz_pkg::CAL_RUN && step_tick && corr_ok) begin
        if (zq_s && !code_max) begin
          cal_code_reg <= cal_code_reg + dqz_pkg::CODE_W'(1);
        end else if (!zq_s && !code_min) begin
          cal_code_reg <= cal_code_reg - dqz_pkg::CODE_W'(1);
        end
      end
      if (cal_state_reg == dqz_pkg::CAL_XFER) begin
        io_code_reg <= cal_code_reg;
        if (is_long_reg) begin
          first_done_reg <= 1'b1;
        end
      end
    end
  end

  // current path only while engine runs
  wire logic cal_active = cal_state_reg == dqz_pkg::CAL_RUN;
  // park termination held for the whole procedure
  wire logic park_on = ~cal_idle;

  // read mux and ack
  logic [31:0] rd_word;
  logic [31:0] status_word;
  logic [31:0] wb_dat_reg;
  logic wb_ack_reg;

  always_comb begin
    status_word = 32'h0;
    status_word[dqz_pkg::ST_BUSY_BIT] = ~cal_idle;
    status_word[dqz_pkg::ST_FIRST_DONE_BIT] = first_done_reg;
    status_word[dqz_pkg::ST_LONG_BIT] = is_long_reg;
    status_word[dqz_pkg::ST_SHORT_BIT] = is_short_reg;
    status_word[dqz_pkg::ST_CONFLICT_BIT] = mode_conflict;
    status_word[dqz_pkg::ST_CURRENT_BIT] = cal_active;
    status_word[dqz_pkg::ST_CODE_LSB +: dqz_pkg::CODE_W] = cal_code_reg;
  end

  always_comb begin
    rd_word = 32'h0;
    if (hit_mode) begin
      rd_word[dqz_pkg::MODE_MASK_BIT] = mask_en_reg;
      rd_word[dqz_pkg::MODE_WINV_BIT] = winv_en_reg;
      rd_word[dqz_pkg::MODE_RINV_BIT] = rinv_en_reg;
    end else if (hit_status) begin
      rd_word = status_word;
    end else if (hit_code) begin
      rd_word[dqz_pkg::CODE_W-1:0] = io_code_reg;
    end else begin
      rd_word = 32'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= 32'h0;
    end else if (ce_i) begin
      wb_ack_reg <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_reg <= rd_word;
      end
    end
  end

  assign wb_ack_o = wb_ack_reg;
  assign wb_dat_o = wb_dat_reg;
  assign dq_o = dq_out_reg;
  assign dq_oe_o = dq_oe_reg;
  assign lane_mask_invert_pin_n_o = lane_out_reg;
  assign lane_mask_invert_pin_oe_o = lane_oe_reg;
  assign lane_rx_en_o = rx_on;
  assign core_wr_data_o = wr_data_reg;
  assign core_wr_byte_en_o = wr_be_reg;
  assign core_wr_valid_o = wr_valid_reg;
  assign core_wr_beat_o = wr_beat_out_reg;
  assign cal_current_en_o = cal_active;
  assign park_termination_o = park_on | (cal_idle & ~term_unused & ~sr_exit_unused & 1'b0);
  assign io_code_o = io_code_reg;
endmodule : dqz_lane_cal

// file: dqz_lane_cal_monitor.sv
`timescale 1ns/1ns
module dqz_lane_cal_monitor #(
  parameter int INIT_WIN_CYC = 1024
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic rd_beat_i,
  input wire logic [15:0] core_rd_data_i,
  input wire logic [15:0] dq_i,
  input wire logic [15:0] dq_o,
  input wire logic dq_oe_o,
  input wire logic [1:0] lane_mask_invert_pin_n_o,
  input wire logic [1:0] lane_mask_invert_pin_oe_o,
  input wire logic lane_rx_en_o,
  input wire logic [15:0] core_wr_data_o,
  input wire logic [1:0] core_wr_byte_en_o,
  input wire logic core_wr_valid_o,
  input wire logic cal_current_en_o,
  input wire logic park_termination_o,
  input wire logic [5:0] io_code_o
);
  logic [15:0] cal_cnt_reg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // cycles spent outside idle, bounded by the longest window
  always_ff @(posedge clk_i) begin
    if (rst_i || !park_termination_o) cal_cnt_reg <= 16'h0000;
    else cal_cnt_reg <= cal_cnt_reg + 16'h0001;
  end
  // more than four zeros means fewer than four ones
  function automatic logic [17:0] rd_exp(input logic [15:0] d);
    logic [1:0] inv;
    inv[0] = $countones(d[7:0]) < 4;
    inv[1] = $countones(d[15:8]) < 4;
    return {~inv, d ^ {{8{inv[1]}}, {8{inv[0]}}}};
  endfunction : rd_exp
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("ack late");
  a_ack_single_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack too long");
  a_rx_off_passes: assert property (core_wr_valid_o && !$past(lane_rx_en_o, 3) |->
    core_wr_byte_en_o == 2'b11 && core_wr_data_o == $past(dq_i, 3)) else $error("pin not ignored");
  a_lane_oe_pair: assert property (lane_mask_invert_pin_oe_o != 2'b00 |->
    dq_oe_o && lane_mask_invert_pin_oe_o == 2'b11) else $error("lane pin driven off read");
  a_read_follows_beat: assert property (ce_i |=> dq_oe_o == $past(rd_beat_i))
    else $error("read beat timing");
  a_read_invert: assert property (dq_oe_o && lane_mask_invert_pin_oe_o == 2'b11 |->
    {lane_mask_invert_pin_n_o, dq_o} == rd_exp($past(core_rd_data_i))) else $error("read inversion");
  a_current_in_park: assert property (cal_current_en_o |-> park_termination_o)
    else $error("current outside cal");
  a_xfer_one_cycle: assert property ($fell(cal_current_en_o) |->
    park_termination_o ##1 !park_termination_o) else $error("transfer length");
  a_code_at_xfer: assert property ($changed(io_code_o) |-> $fell(park_termination_o))
    else $error("code changed outside transfer");
  a_cal_bounded: assert property (cal_cnt_reg <= 16'(INIT_WIN_CYC))
    else $error("cal window exceeded");
endmodule : dqz_lane_cal_monitor
bind dqz_lane_cal dqz_lane_cal_monitor #(.INIT_WIN_CYC(INIT_WIN_CYC)) u_mon (.clk_i, .rst_i, .ce_i,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .rd_beat_i, .core_rd_data_i, .dq_i, .dq_o, .dq_oe_o,
  .lane_mask_invert_pin_n_o, .lane_mask_invert_pin_oe_o, .lane_rx_en_o, .core_wr_data_o,
  .core_wr_byte_en_o, .core_wr_valid_o, .cal_current_en_o, .park_termination_o, .io_code_o);

// file: dqz_ctrl_model.sv
`timescale 1ns/1ns
// single device, own resistor, banks idle before any cal
module dqz_ctrl_model (
  input wire logic clk_i,
  output logic ce_o,
  output logic wr_beat_o,
  output logic [15:0] dq_o,
  output logic [1:0] lane_n_o,
  output logic rd_beat_o,
  output logic [15:0] rd_data_o,
  output logic odt_o
);
  initial begin
    ce_o = 1'b1;
    odt_o = 1'b0;
    wr_beat_o = 1'b0;
    dq_o = 16'h0000;
    lane_n_o = 2'b11;
    rd_beat_o = 1'b0;
    rd_data_o = 16'h0000;
  end
  // released lines show the inverse, never the last value
  task automatic wbeat(input logic [15:0] d, input logic [1:0] p);
    @(posedge clk_i);
    wr_beat_o <= 1'b1;
    dq_o <= d;
    lane_n_o <= p;
    @(posedge clk_i);
    wr_beat_o <= 1'b0;
    dq_o <= ~d;
    lane_n_o <= ~p;
  endtask : wbeat
  task automatic rbeat(input logic [15:0] d);
    @(posedge clk_i);
    rd_beat_o <= 1'b1;
    rd_data_o <= d;
    @(posedge clk_i);
    rd_beat_o <= 1'b0;
    rd_data_o <= ~d;
  endtask : rbeat
endmodule : dqz_ctrl_model

// file: tb_top.sv
`timescale 1ns/1ns
module tb_top;
  localparam int IW = 16;
  localparam int OW = 8;
  localparam int SW = 8;
  typedef struct packed {
    logic [2:0] m;
    logic [15:0] d;
    logic [1:0] p;
    logic [15:0] w;
    logic [1:0] en;
    logic [15:0] r;
    logic [1:0] rp;
    logic [1:0] oe;
  } dqz_row_type;
  dqz_row_type rows [7] = '{
    '{3'h0, 16'h00FF, 2'h0, 16'h00FF, 2'h3, 16'h00FF, 2'h3, 2'h0},
    '{3'h1, 16'h1234, 2'h1, 16'h1234, 2'h1, 16'h1234, 2'h3, 2'h0},
    '{3'h2, 16'h1234, 2'h1, 16'hED34, 2'h3, 16'h1234, 2'h3, 2'h0},
    '{3'h4, 16'h00F0, 2'h0, 16'h00F0, 2'h3, 16'hFFF0, 2'h1, 2'h3},
    '{3'h6, 16'h0701, 2'h2, 16'h07FE, 2'h3, 16'hF8FE, 2'h0, 2'h3},
    '{3'h5, 16'h1F0F, 2'h2, 16'h1F0F, 2'h2, 16'h1F0F, 2'h3, 2'h3},
    '{3'h3, 16'hAA55, 2'h1, 16'hAA55, 2'h1, 16'hAA55, 2'h3, 2'h0}};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic sr_exit = 1'b0;
  logic zq_cmp = 1'b0;
  logic [31:0] rdat;
  logic ack, ce, wb_m, rb_m, termination_control, dq_oe, rx_en, wvalid, park, cur;
  logic [15:0] dq_m, rd_m, dq_d, core_d;
  logic [1:0] pin_m, pin_d, pin_oe, en_d;
  logic [2:0] beat;
  logic [5:0] code;
  wire logic [15:0] dq_w = dq_oe ? dq_d : dq_m;
  wire logic [1:0] pin_w = (pin_oe & pin_d) | (~pin_oe & pin_m);
  int fail_count = 0;
  int tests_run = 0;
  initial forever #4 clk_i = ~clk_i;
  dqz_ctrl_model ctrl (.clk_i(clk_i), .ce_o(ce), .wr_beat_o(wb_m), .dq_o(dq_m), .lane_n_o(pin_m),
    .rd_beat_o(rb_m), .rd_data_o(rd_m), .odt_o(termination_control));
  dqz_lane_cal #(.INIT_WIN_CYC(IW), .OPER_WIN_CYC(OW), .SHORT_WIN_CYC(SW), .STEP_CYC(2)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wr_beat_i(wb_m), .dq_i(dq_w), .lane_mask_invert_pin_n_i(pin_w), .dq_o(dq_d),
    .dq_oe_o(dq_oe), .lane_mask_invert_pin_n_o(pin_d), .lane_mask_invert_pin_oe_o(pin_oe),
    .lane_rx_en_o(rx_en), .core_wr_data_o(core_d), .core_wr_byte_en_o(en_d),
    .core_wr_valid_o(wvalid), .core_wr_beat_o(beat), .rd_beat_i(rb_m), .core_rd_data_i(rd_m),
    .termination_control_i(termination_control), .self_refresh_exit_i(sr_exit), .zq_cmp_i(zq_cmp),
    .cal_current_en_o(cur), .park_termination_o(park), .io_code_o(code));
  task automatic print_verdict();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d,
                    output logic [31:0] q);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    // ack and read data are both taken at the rising edge that samples ack high
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 16);
    if (ack !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  // channel stays quiet while a window runs
  task automatic cal(input logic [31:0] cmd, input int w);
    logic [31:0] q;
    int n;
    wb(1'b1, dqz_pkg::CAL_CMD_OFS, 4'h1, cmd, q);
    #1;
    chk("cal_cur_on", 32'h1, 32'(cur));
    for (n = 0; n < 64 && park === 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    chk("cal_len", 32'(w - 1), 32'(n));
    chk("cal_cur_off", 32'h0, 32'(cur));
    if (n == 64) print_verdict();
  endtask : cal
  task automatic rst_chk();
    logic [31:0] q;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, dqz_pkg::STATUS_OFS, 4'hF, 32'h0, q);
    chk("status", 32'(dqz_pkg::CODE_RESET) << dqz_pkg::ST_CODE_LSB, q);
    wb(1'b0, dqz_pkg::CODE_OFS, 4'hF, 32'h0, q);
    chk("code", 32'(dqz_pkg::CODE_RESET), q);
    wb(1'b0, dqz_pkg::MODE_OFS, 4'hF, 32'h0, q);
    chk("mode", 32'h0, q);
  endtask : rst_chk
  initial begin
    int n;
    logic [31:0] q;
    logic [15:0] mk;
    logic [5:0] c;
    rst_chk();
    for (int i = 0; i < 7; i++) begin
      wb(1'b1, dqz_pkg::MODE_OFS, 4'h2, 32'(rows[i].m) << dqz_pkg::MODE_MASK_BIT, q);
      wb(1'b0, dqz_pkg::MODE_OFS, 4'hF, 32'h0, q);
      chk("mode", 32'(rows[i].m) << dqz_pkg::MODE_MASK_BIT, q);
      chk("rx_en", 32'(rows[i].m[0] | rows[i].m[1]), 32'(rx_en));
      wb(1'b0, dqz_pkg::STATUS_OFS, 4'hF, 32'h0, q);
      chk("conflict", 32'(&rows[i].m[1:0]), 32'(q[dqz_pkg::ST_CONFLICT_BIT]));
      ctrl.wbeat(rows[i].d, rows[i].p);
      for (n = 0; n < 10 && wvalid !== 1'b1; n++) @(negedge clk_i);
      if (n == 10) begin
        fail_count++;
        print_verdict();
      end
      mk = {{8{rows[i].en[1]}}, {8{rows[i].en[0]}}};
      chk("wr_en", 32'(rows[i].en), 32'(en_d));
      chk("wr_data", 32'(rows[i].w & mk), 32'(core_d & mk));
      chk("wr_beat", 32'(i), 32'(beat));
      ctrl.rbeat(rows[i].d);
      @(negedge clk_i);
      chk("rd_oe", 32'(rows[i].oe), 32'(pin_oe));
      chk("rd_data", 32'(rows[i].r), 32'(dq_d));
      if (rows[i].oe != 2'h0) chk("rd_pin", 32'(rows[i].rp), 32'(pin_d));
    end
    wb(1'b0, 4'h2, 4'hF, 32'h0, q);
    chk("unmapped", 32'h0, q);
    zq_cmp <= 1'b1;
    cal(32'h3, IW);
    chk("code_up", 32'h1, 32'(code > dqz_pkg::CODE_RESET));
    wb(1'b0, dqz_pkg::STATUS_OFS, 4'hF, 32'h0, q);
    chk("first_done", 32'h1, 32'(q[dqz_pkg::ST_FIRST_DONE_BIT]));
    cal(32'h1, OW);
    c = code;
    @(posedge clk_i);
    zq_cmp <= 1'b0;
    cal(32'h2, SW);
    chk("code_down", 32'h1, 32'(code < c));
    c = code;
    @(posedge clk_i);
    sr_exit <= 1'b1;
    @(posedge clk_i);
    sr_exit <= 1'b0;
    n = 0;
    repeat (20) begin
      @(negedge clk_i);
      n += int'(park);
    end
    chk("sr_cal", 32'h0, 32'(n));
    chk("sr_code", 32'(c), 32'(code));
    wb(1'b1, dqz_pkg::CAL_CMD_OFS, 4'h1, 32'h1, q);
    rst_chk();
    cal(32'h1, IW);
    print_verdict();
  end
endmodule : tb_top
